// ===== design/acp_pkg.sv
package acp_pkg;
  localparam int ACP_AW = 4;
  localparam int ACP_DW = 32;
  localparam int ACP_CH = 16;
  // register byte addresses
  localparam logic [ACP_AW-1:0] ACP_OFS_CFG    = 4'h0;
  localparam logic [ACP_AW-1:0] ACP_OFS_PINLO  = 4'h4;
  localparam logic [ACP_AW-1:0] ACP_OFS_PINMID = 4'h8;
  localparam logic [ACP_AW-1:0] ACP_OFS_STAT   = 4'hc;
  localparam logic [7:0] ACP_RST_CFG = 8'h00;
  localparam logic [7:0] ACP_RST_PIN = 8'h00;
  // converter_config field positions
  localparam int ACP_LP_BIT  = 7;
  localparam int ACP_DIV_HI  = 6;
  localparam int ACP_DIV_LO  = 5;
  localparam int ACP_LS_BIT  = 4;
  localparam int ACP_MODE_HI = 3;
  localparam int ACP_MODE_LO = 2;
  localparam int ACP_SRC_HI  = 1;
  localparam int ACP_SRC_LO  = 0;
  // status fields
  localparam int ACP_ST_RSVD  = 0;
  localparam int ACP_ST_ASYNC = 1;
  localparam int ACP_ST_PH_LO = 2;
  localparam int ACP_ST_PH_HI = 4;
  localparam logic [1:0] ACP_SRC_BUS   = 2'h0;
  localparam logic [1:0] ACP_SRC_BUS2  = 2'h1;
  localparam logic [1:0] ACP_SRC_ALT   = 2'h2;
  localparam logic [1:0] ACP_SRC_ASYNC = 2'h3;
  localparam logic [1:0] ACP_MODE_8  = 2'h0;
  localparam logic [1:0] ACP_MODE_10 = 2'h2;
  localparam logic [1:0] ACP_RESP_OKAY   = 2'h0;
  localparam logic [1:0] ACP_RESP_SLVERR = 2'h2;
  typedef enum logic [2:0] {
    ACP_REG_CFG, ACP_REG_PINLO, ACP_REG_PINMID, ACP_REG_STAT, ACP_REG_NONE
  } acp_reg_t;
endpackage

// ===== design/acp_clkdiv.sv
`timescale 1ns/1ps
module acp_clkdiv
  import acp_pkg::*;
#(
  parameter int CNT_W = 3
) (
  input  wire logic             sys_clk,
  input  wire logic             rst_n,
  input  wire logic             restart,
  input  wire logic             tick_in,
  input  wire logic [1:0]       div_sel,
  output logic                  tick_out,
  output logic [CNT_W-1:0]      phase
);
  logic [CNT_W-1:0] cnt;
  logic [CNT_W-1:0] next_cnt;
  logic             next_tick;

  // code n divides by 2**n, so the terminal count is 2**n - 1
  function automatic logic [CNT_W-1:0] last_count(input logic [1:0] sel);
    last_count = CNT_W'((1 << sel) - 1);
  endfunction

  always_comb begin
    next_cnt  = cnt;
    next_tick = 1'b0;
    if (restart) begin
      next_cnt = '0;
    end else if (tick_in) begin
      if (cnt >= last_count(div_sel)) begin
        next_cnt  = '0;
        next_tick = 1'b1;
      end else begin
        next_cnt = cnt + CNT_W'(1);
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt      <= '0;
      tick_out <= 1'b0;
    end else begin
      cnt      <= next_cnt;
      tick_out <= next_tick;
    end
  end

  assign phase = cnt;

  AST_DIV_PERIOD: assert property (
    @(posedge sys_clk) disable iff (!rst_n || restart)
    (tick_in && div_sel == 2'h0) |=> tick_out)
    else $error("divide by one did not pass the input tick");
endmodule // acp_clkdiv

// ===== design/acp_top.sv
// Added by the designer: the address map and the AXI4-Lite register port.
`timescale 1ns/1ps
// What this block does
// - bit 7 picks low power or speed
// - bits 6:5 divide input clock 1/2/4/8
// - bit 4 picks long sample time
// - bits 3:2 select 8 or 10 bit
// - bits 1:0 pick input clock source
// - low pin register bits map channels 0-7
// - mid pin register bits map channels 8-15
// - set bit removes port control of pin
// - analog pin: hi-z, input zero, no pullup
// - reset selects the bus clock
// - async clock runs in wait and stop3
module acp_top
  import acp_pkg::*;
#(
  parameter int CH = ACP_CH
) (
  input  wire logic              sys_clk,
  input  wire logic              rst_n,
  input  wire logic [ACP_AW-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [ACP_DW-1:0] s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [ACP_AW-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [ACP_DW-1:0]      s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  input  wire logic              alternate_clock,
  input  wire logic              async_conversion_clock,
  input  wire logic              wait_mode,
  input  wire logic              stop3_mode,
  output logic                   async_osc_enable,
  output logic                   converter_clock,
  output logic                   low_power_select,
  output logic                   long_sample_select,
  output logic                   mode_10bit,
  output logic                   mode_reserved,
  output logic [CH-1:0]          pin_analog,
  input  wire logic [CH-1:0]     port_out_data,
  input  wire logic [CH-1:0]     port_out_enable,
  input  wire logic [CH-1:0]     port_pullup_enable,
  input  wire logic [CH-1:0]     pin_in,
  output logic [CH-1:0]          pin_out,
  output logic [CH-1:0]          pin_oe,
  output logic [CH-1:0]          pin_pullup,
  output logic [CH-1:0]          port_read_data
);
  logic [7:0]        converter_config;
  logic [7:0]        pin_analog_select_low;
  logic [7:0]        pin_analog_select_mid;
  logic [7:0]        next_config;
  logic [7:0]        next_pin_low;
  logic [7:0]        next_pin_mid;
  logic              aw_held;
  logic              w_held;
  logic [ACP_AW-1:0] aw_addr;
  logic [7:0]        w_byte;
  logic              w_lane0;
  logic              next_aw_held;
  logic              next_w_held;
  logic [ACP_AW-1:0] next_aw_addr;
  logic [7:0]        next_w_byte;
  logic              next_w_lane0;
  logic              next_bvalid;
  logic [1:0]        next_bresp;
  logic              next_rvalid;
  logic [1:0]        next_rresp;
  logic [ACP_DW-1:0] next_rdata;
  logic              do_write;
  logic              cfg_write;
  logic              half_tick;
  logic              alt_prev;
  logic              async_prev;
  logic              src_tick;
  logic [2:0]        div_phase;
  logic [1:0]        clk_src;
  logic [1:0]        div_sel;
  logic [1:0]        conv_mode;
  logic [7:0]        status;

  function automatic acp_reg_t reg_decode(input logic [ACP_AW-1:0] a);
    case (a)
      ACP_OFS_CFG:    reg_decode = ACP_REG_CFG;
      ACP_OFS_PINLO:  reg_decode = ACP_REG_PINLO;
      ACP_OFS_PINMID: reg_decode = ACP_REG_PINMID;
      ACP_OFS_STAT:   reg_decode = ACP_REG_STAT;
      default:        reg_decode = ACP_REG_NONE;
    endcase
  endfunction

  assign clk_src   = converter_config[ACP_SRC_HI:ACP_SRC_LO];
  assign div_sel   = converter_config[ACP_DIV_HI:ACP_DIV_LO];
  assign conv_mode = converter_config[ACP_MODE_HI:ACP_MODE_LO];

  // write side: address and data are taken in either order or in the same cycle
  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready  = !w_held && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  assign do_write      = aw_held && w_held;
  assign cfg_write     = do_write && w_lane0
                         && reg_decode(aw_addr) == ACP_REG_CFG;

  always_comb begin
    next_aw_held = aw_held;
    next_w_held  = w_held;
    next_aw_addr = aw_addr;
    next_w_byte  = w_byte;
    next_w_lane0 = w_lane0;
    next_bvalid  = s_axi_bvalid;
    next_bresp   = s_axi_bresp;
    next_config  = converter_config;
    next_pin_low = pin_analog_select_low;
    next_pin_mid = pin_analog_select_mid;
    if (s_axi_awvalid && s_axi_awready) begin
      next_aw_held = 1'b1;
      next_aw_addr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_w_held  = 1'b1;
      next_w_byte  = s_axi_wdata[7:0];
      next_w_lane0 = s_axi_wstrb[0];
    end
    if (s_axi_bvalid && s_axi_bready) begin
      next_bvalid = 1'b0;
    end
    if (do_write) begin
      next_aw_held = 1'b0;
      next_w_held  = 1'b0;
      next_bvalid  = 1'b1;
      next_bresp   = ACP_RESP_OKAY;
      // registers are one byte wide, so only lane 0 carries data
      case (reg_decode(aw_addr))
        ACP_REG_CFG: begin
          if (w_lane0) next_config = w_byte;
        end
        ACP_REG_PINLO: begin
          if (w_lane0) next_pin_low = w_byte;
        end
        ACP_REG_PINMID: begin
          if (w_lane0) next_pin_mid = w_byte;
        end
        ACP_REG_STAT: begin
          next_bresp = ACP_RESP_OKAY;
        end
        default: begin
          next_bresp = ACP_RESP_SLVERR;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      aw_held               <= 1'b0;
      w_held                <= 1'b0;
      aw_addr               <= '0;
      w_byte                <= '0;
      w_lane0               <= 1'b0;
      s_axi_bvalid          <= 1'b0;
      s_axi_bresp           <= ACP_RESP_OKAY;
      converter_config      <= ACP_RST_CFG;
      pin_analog_select_low <= ACP_RST_PIN;
      pin_analog_select_mid <= ACP_RST_PIN;
    end else begin
      aw_held               <= next_aw_held;
      w_held                <= next_w_held;
      aw_addr               <= next_aw_addr;
      w_byte                <= next_w_byte;
      w_lane0               <= next_w_lane0;
      s_axi_bvalid          <= next_bvalid;
      s_axi_bresp           <= next_bresp;
      converter_config      <= next_config;
      pin_analog_select_low <= next_pin_low;
      pin_analog_select_mid <= next_pin_mid;
    end
  end

  // read side
  assign status = {3'h0, div_phase, async_osc_enable, mode_reserved};

  always_comb begin
    next_rvalid = s_axi_rvalid;
    next_rresp  = s_axi_rresp;
    next_rdata  = s_axi_rdata;
    if (s_axi_rvalid && s_axi_rready) begin
      next_rvalid = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      next_rvalid = 1'b1;
      next_rresp  = ACP_RESP_OKAY;
      case (reg_decode(s_axi_araddr))
        ACP_REG_CFG:    next_rdata = {24'h0, converter_config};
        ACP_REG_PINLO:  next_rdata = {24'h0, pin_analog_select_low};
        ACP_REG_PINMID: next_rdata = {24'h0, pin_analog_select_mid};
        ACP_REG_STAT:   next_rdata = {24'h0, status};
        default: begin
          next_rdata = '0;
          next_rresp = ACP_RESP_SLVERR;
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rresp  <= ACP_RESP_OKAY;
      s_axi_rdata  <= '0;
    end else begin
      s_axi_rvalid <= next_rvalid;
      s_axi_rresp  <= next_rresp;
      s_axi_rdata  <= next_rdata;
    end
  end

  // clock source selection; bus-derived sources halt in stop3
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      half_tick  <= 1'b0;
      alt_prev   <= 1'b0;
      async_prev <= 1'b0;
    end else begin
      half_tick  <= !half_tick;
      alt_prev   <= alternate_clock;
      async_prev <= async_conversion_clock;
    end
  end

  always_comb begin
    case (clk_src)
      ACP_SRC_BUS:   src_tick = !stop3_mode;
      ACP_SRC_BUS2:  src_tick = !stop3_mode && half_tick;
      ACP_SRC_ALT:   src_tick = !stop3_mode && alternate_clock
                                && !alt_prev;
      ACP_SRC_ASYNC: src_tick = async_conversion_clock && !async_prev;
      default:       src_tick = 1'b0;
    endcase
  end

  // async oscillator stays on through wait and stop3 once selected
  assign async_osc_enable = clk_src == ACP_SRC_ASYNC;

  // divider restarts on a config write so a new ratio begins cleanly
  acp_clkdiv #(.CNT_W(3)) u_div (
    .sys_clk  (sys_clk),
    .rst_n    (rst_n),
    .restart  (cfg_write),
    .tick_in  (src_tick),
    .div_sel  (div_sel),
    .tick_out (converter_clock),
    .phase    (div_phase)
  );

  assign low_power_select   = converter_config[ACP_LP_BIT];
  assign long_sample_select = converter_config[ACP_LS_BIT];
  assign mode_10bit         = conv_mode == ACP_MODE_10;
  assign mode_reserved      = conv_mode[0];
  assign pin_analog = {pin_analog_select_mid, pin_analog_select_low};

  genvar g;
  generate
    for (g = 0; g < CH; g++) begin : g_pin
      // an analog pin is cut off from the port completely
      assign pin_oe[g]     = !pin_analog[g] && port_out_enable[g];
      assign pin_out[g]    = !pin_analog[g] && port_out_data[g];
      assign pin_pullup[g] = !pin_analog[g]
                             && port_pullup_enable[g];
      assign port_read_data[g] = !pin_analog[g] && pin_in[g];
    end
  endgenerate

  AST_RESET_CLEAR: assert property (
    @(posedge sys_clk) $rose(rst_n) |->
      converter_config == 8'h00 && pin_analog == '0)
    else $error("registers not cleared by reset");
  AST_RESET_BUS_SRC: assert property (
    @(posedge sys_clk) $rose(rst_n) |-> clk_src == ACP_SRC_BUS)
    else $error("bus clock not selected after reset");
  AST_LP_WRITE: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    cfg_write |=> low_power_select == $past(w_byte[ACP_LP_BIT]))
    else $error("low power bit did not follow write");
  AST_DIV8: assert property (
    @(posedge sys_clk) disable iff (!rst_n || cfg_write || stop3_mode)
    (converter_clock && clk_src == ACP_SRC_BUS && div_sel == 2'h3)
      |=> !converter_clock [*7] ##1 converter_clock)
    else $error("divide by eight period wrong");
  AST_LS_CFG: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    cfg_write |=> long_sample_select == $past(w_byte[ACP_LS_BIT]))
    else $error("sample time bit did not follow write");
  AST_MODE: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    mode_10bit |-> conv_mode == 2'h2 && !mode_reserved)
    else $error("mode decode wrong");
  AST_ALT_SRC: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    (clk_src == ACP_SRC_ALT && !stop3_mode)
      |-> src_tick == (alternate_clock && !alt_prev))
    else $error("alternate clock edge not used");
  AST_PINLO_MAP: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    (do_write && w_lane0 && reg_decode(aw_addr) == ACP_REG_PINLO)
      |=> pin_analog[7:0] == $past(w_byte))
    else $error("low pin bits not mapped to channels 0-7");
  AST_PINMID_MAP: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    (do_write && w_lane0 && reg_decode(aw_addr) == ACP_REG_PINMID)
      |=> pin_analog[15:8] == $past(w_byte))
    else $error("mid pin bits not mapped to channels 8-15");
  AST_PORT_KEEP: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    pin_analog == '0 |-> pin_oe == port_out_enable
      && port_read_data == pin_in)
    else $error("port control lost on digital pin");
  AST_ANALOG_OFF: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    pin_analog[0] |-> !pin_oe[0] && !pin_pullup[0] && !port_read_data[0])
    else $error("analog pin still driven or read");
  AST_ASYNC_STOP3: assert property (
    @(posedge sys_clk) disable iff (!rst_n)
    (clk_src == ACP_SRC_ASYNC && (stop3_mode || wait_mode))
      |-> async_osc_enable)
    else $error("async clock halted in low power mode");
  COV_WRITE_CFG: cover property (@(posedge sys_clk) cfg_write);
  COV_ASYNC_STOP3: cover property (
    @(posedge sys_clk) async_osc_enable && stop3_mode && converter_clock);
  COV_READ_ERR: cover property (
    @(posedge sys_clk) s_axi_rvalid && s_axi_rresp == ACP_RESP_SLVERR);
endmodule // acp_top

// ===== tb/tb_adc_config_pin_control.sv
`timescale 1ns/1ps
module tb_adc_config_pin_control;
  import acp_pkg::*;
  logic              sys_clk, rst_n;
  logic [ACP_AW-1:0] s_axi_awaddr, s_axi_araddr;
  logic              s_axi_awvalid, s_axi_awready, s_axi_wvalid;
  logic              s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic [ACP_DW-1:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]        s_axi_wstrb;
  logic [1:0]        s_axi_bresp, s_axi_rresp;
  logic              s_axi_arvalid, s_axi_arready;
  logic              s_axi_rvalid, s_axi_rready;
  logic              alternate_clock, async_conversion_clock;
  logic              wait_mode, stop3_mode, async_osc_enable;
  logic              converter_clock, low_power_select;
  logic              long_sample_select, mode_10bit, mode_reserved;
  logic [15:0]       pin_analog, port_out_data, port_out_enable;
  logic [15:0]       port_pullup_enable, pin_in, pin_out, pin_oe;
  logic [15:0]       pin_pullup, port_read_data;
  logic [1:0]        resp;
  logic [31:0]       rd;
  logic [3:0]        src_cnt;
  int                miscompares, compares, cyc;

  acp_top dut (.sys_clk(sys_clk), .rst_n(rst_n),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready), .alternate_clock(alternate_clock),
    .async_conversion_clock(async_conversion_clock),
    .wait_mode(wait_mode), .stop3_mode(stop3_mode),
    .async_osc_enable(async_osc_enable),
    .converter_clock(converter_clock),
    .low_power_select(low_power_select),
    .long_sample_select(long_sample_select), .mode_10bit(mode_10bit),
    .mode_reserved(mode_reserved), .pin_analog(pin_analog),
    .port_out_data(port_out_data), .port_out_enable(port_out_enable),
    .port_pullup_enable(port_pullup_enable), .pin_in(pin_in),
    .pin_out(pin_out), .pin_oe(pin_oe), .pin_pullup(pin_pullup),
    .port_read_data(port_read_data));

  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end

  // alternate source has a 4-cycle period, async source an 8-cycle one
  always @(posedge sys_clk) begin
    src_cnt <= src_cnt + 4'h1;
    alternate_clock <= src_cnt[1];
    async_conversion_clock <= src_cnt[2];
  end

  task automatic stop_test();
    $display("compares=%0d miscompares=%0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc >= 30000) begin
      miscompares++;
      stop_test();
    end
  end

  task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] %s expected=%h seen=%h", name, exp, seen);
    end
  endtask

  // both halves offered together, each released as soon as it is taken
  task automatic axi_wr(logic [3:0] a, logic [7:0] d, logic [3:0] be = 4'hf);
    int n;
    n = 0;
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= {24'h000000, d};
    s_axi_wstrb <= be;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge sys_clk);
      n++;
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid && n < 100);
    resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
    if (n >= 100) check("write wait", 32'h1, 32'h0);
    @(posedge sys_clk);
  endtask

  task automatic axi_rd(logic [3:0] a);
    int n;
    n = 0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge sys_clk);
      n++;
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid && n < 100);
    rd = s_axi_rdata;
    resp = s_axi_rresp;
    s_axi_rready <= 1'b0;
    if (n >= 100) check("read wait", 32'h1, 32'h0);
    @(posedge sys_clk);
  endtask

  // cycles between two pulses of the converter clock
  task automatic period(output int p);
    int n;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (converter_clock !== 1'b1 && n < 200);
    p = 0;
    do begin
      @(posedge sys_clk);
      p++;
    end while (converter_clock !== 1'b1 && p < 200);
  endtask

  task automatic test_reset();
    axi_rd(ACP_OFS_CFG);
    check("cfg reset", rd, 32'h0);
    check("src reset", {30'h0, rd[1:0]}, {30'h0, ACP_SRC_BUS});
    axi_rd(ACP_OFS_PINLO);
    check("pinlo reset", rd, 32'h0);
    axi_rd(ACP_OFS_PINMID);
    check("pinmid reset", rd, 32'h0);
    check("analog reset", {16'h0, pin_analog}, 32'h0);
    $display("test reset done");
  endtask

  task automatic test_fields();
    axi_wr(ACP_OFS_CFG, 8'h98);
    check("low power", {31'h0, low_power_select}, 32'h1);
    check("long sample", {31'h0, long_sample_select}, 32'h1);
    check("mode 10", {31'h0, mode_10bit}, 32'h1);
    check("mode rsvd a", {31'h0, mode_reserved}, 32'h0);
    axi_rd(ACP_OFS_CFG);
    check("cfg readback", rd, 32'h98);
    axi_wr(ACP_OFS_CFG, 8'h04);
    check("hs select", {31'h0, low_power_select}, 32'h0);
    check("short sample", {31'h0, long_sample_select}, 32'h0);
    check("mode 8", {31'h0, mode_10bit}, 32'h0);
    check("mode rsvd b", {31'h0, mode_reserved}, 32'h1);
    axi_wr(ACP_OFS_CFG, 8'h0c);
    check("mode rsvd c", {31'h0, mode_reserved}, 32'h1);
    axi_rd(ACP_OFS_STAT);
    check("stat rd", rd, 32'h1);
    axi_wr(ACP_OFS_STAT, 8'hff);
    check("stat wr", {30'h0, resp}, {30'h0, ACP_RESP_OKAY});
    // byte lane 0 disabled: the register must keep its value
    axi_wr(ACP_OFS_CFG, 8'hff, 4'he);
    axi_rd(ACP_OFS_CFG);
    check("lane0 only", rd, 32'h0c);
    $display("test fields done");
  endtask

  task automatic test_divide();
    int p;
    int base [4] = '{1, 2, 4, 8};
    for (int s = 0; s < 4; s++) begin
      for (int d = 0; d < 4; d++) begin
        axi_wr(ACP_OFS_CFG, {1'b0, 2'(d), 3'b000, 2'(s)});
        check("osc enable", {31'h0, async_osc_enable},
              (s == 3) ? 32'h1 : 32'h0);
        period(p);
        period(p);
        check("cc period", 32'(p), 32'(base[s] << d));
      end
    end
    $display("test divide done");
  endtask

  task automatic test_lowpower_modes();
    int p, hits;
    hits = 0;
    axi_wr(ACP_OFS_CFG, 8'h00);
    stop3_mode <= 1'b1;
    repeat (4) @(posedge sys_clk);
    for (int i = 0; i < 20; i++) begin
      @(posedge sys_clk);
      if (converter_clock !== 1'b0) hits++;
    end
    check("stop3 bus", 32'(hits), 32'h0);
    wait_mode <= 1'b1;
    axi_wr(ACP_OFS_CFG, 8'h03);
    period(p);
    period(p);
    check("stop3 async", 32'(p), 32'h8);
    check("osc in stop3", {31'h0, async_osc_enable}, 32'h1);
    stop3_mode <= 1'b0;
    wait_mode <= 1'b0;
    @(posedge sys_clk);
    $display("test stop modes done");
  endtask

  task automatic test_pins();
    logic [15:0] a;
    a = 16'h3ca5;
    port_out_data <= 16'h5a5a;
    port_out_enable <= 16'hffff;
    port_pullup_enable <= 16'hf0f0;
    pin_in <= 16'h6969;
    axi_wr(ACP_OFS_PINLO, a[7:0]);
    axi_wr(ACP_OFS_PINMID, a[15:8]);
    check("analog map", {16'h0, pin_analog}, {16'h0, a});
    check("pin out", {16'h0, pin_out}, {16'h0, 16'h5a5a & ~a});
    check("pin oe", {16'h0, pin_oe}, {16'h0, ~a});
    check("pullup", {16'h0, pin_pullup}, {16'h0, 16'hf0f0 & ~a});
    check("port read", {16'h0, port_read_data},
          {16'h0, 16'h6969 & ~a});
    axi_rd(ACP_OFS_PINMID);
    check("pinmid rd", rd, {24'h0, a[15:8]});
    axi_wr(ACP_OFS_PINLO, 8'h00);
    check("release", {16'h0, pin_oe}, {16'h0, ~{a[15:8], 8'h00}});
    $display("test pins done");
  endtask

  task automatic test_unmapped();
    axi_rd(4'hd);
    check("unmapped rresp", {30'h0, resp}, {30'h0, ACP_RESP_SLVERR});
    check("unmapped rdata", rd, 32'h0);
    axi_wr(4'hd, 8'hff);
    check("unmapped bresp", {30'h0, resp}, {30'h0, ACP_RESP_SLVERR});
    $display("test unmapped done");
  endtask

  initial begin
    miscompares = 0;
    compares = 0;
    cyc = 0;
    src_cnt = 4'h0;
    alternate_clock = 1'b0;
    async_conversion_clock = 1'b0;
    rst_n = 1'b0;
    s_axi_awaddr = '0;
    s_axi_awvalid = 1'b0;
    s_axi_wdata = '0;
    s_axi_wstrb = 4'h0;
    s_axi_wvalid = 1'b0;
    s_axi_bready = 1'b0;
    s_axi_araddr = '0;
    s_axi_arvalid = 1'b0;
    s_axi_rready = 1'b0;
    wait_mode = 1'b0;
    stop3_mode = 1'b0;
    port_out_data = 16'h0;
    port_out_enable = 16'h0;
    port_pullup_enable = 16'h0;
    pin_in = 16'h0;
    repeat (3) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(posedge sys_clk);
    test_reset();
    test_fields();
    test_divide();
    test_lowpower_modes();
    test_pins();
    test_unmapped();
    stop_test();
  end
endmodule // tb_adc_config_pin_control
